/* verilog/dhi_defs.svh */
`ifndef DHI_DEFS_SVH
`define DHI_DEFS_SVH
// Strap codes {bus_strap_a, bus_strap_b}
`define DHI_STRAP_8080 2'b11
`define DHI_STRAP_I2C 2'b10
`define DHI_STRAP_6800 2'b01
`define DHI_STRAP_SPI 2'b00
`define DHI_BYTE_BITS 8
`define DHI_SPI_LAST_BIT 3'h7
`define DHI_ZERO_BYTE 8'h00
`define DHI_I2C_ADDR_DEF 7'h3C
`define DHI_FRAME_CYC_DEF 16'h0800
`define DHI_FRAME_PULSE_DEF 16'h0010
`endif

/* verilog/dhi_pkg.sv */
package dhi_pkg;
  typedef enum logic [1:0] {
    DHI_M8080,
    DHI_MI2C,
    DHI_M6800,
    DHI_MSPI
  } dhi_mode_e;
  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } dhi_byte_s;
endpackage

/* verilog/dhi_frame_sync.sv */
`timescale 1ns/1ps
`include "dhi_defs.svh"
module dhi_frame_sync
  import dhi_pkg::*;
#(
  parameter logic [15:0] FRAME_CYC = `DHI_FRAME_CYC_DEF,
  parameter logic [15:0] PULSE_CYC = `DHI_FRAME_PULSE_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic srst,
  output logic frame_sync_out
);
  initial begin
    if (PULSE_CYC == 16'h0000 || PULSE_CYC >= FRAME_CYC) begin
      $error("dhi_frame_sync: bad pulse or frame length");
    end
  end
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic fs_ff;
  logic nxt_fs;
  always_comb begin
    nxt_cnt = (cnt_ff == FRAME_CYC - 16'h0001) ? 16'h0000 : cnt_ff + 16'h0001;
    nxt_fs = (nxt_cnt < PULSE_CYC);
  end
  // R09: refresh frame marker
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      // Park one count before wrap so the first marker opens a whole frame
      cnt_ff <= FRAME_CYC - 16'h0001;
      fs_ff <= 1'b0;
    end else if (srst) begin
      // R08: reset pin restarts the frame too
      cnt_ff <= FRAME_CYC - 16'h0001;
      fs_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      fs_ff <= nxt_fs;
    end
  end
  assign frame_sync_out = fs_ff;
  // R09: frame period check
  frame_period_a: assert property (@(posedge clk) disable iff (!rstn || srst)
    $rose(fs_ff) |-> cnt_ff == 16'h0000) else $error("frame sync misplaced"); // R09
  frame_seen_c: cover property (@(posedge clk) disable iff (!rstn) $rose(fs_ff));
endmodule

/* verilog/dhi_host_port.sv */
`timescale 1ns/1ps
`include "dhi_defs.svh"
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R01: In 6800 mode a transfer starts when the enable strobe rises while selected.
// R02: In 6800 mode the direction input high means read and low means write.
// R03: In 8080 mode a read starts when the low-active read strobe falls while selected.
// R04: In 8080 mode a write starts when the low-active write strobe falls while selected.
// R05: The straps pick 8080 for 11, I2C for 10, 6800 for 01 and SPI for 00.
// R06: Data/command high marks bytes as display data and low as commands.
// R07: The bus is ignored whenever the low-active chip select is high.
// R08: Pulling the low-active reset input low reinitialises all state.
// R09: A frame sync output follows the refresh timing for tear-free writes.
// R10: In SPI mode data lines one and two carry serial data and line zero the clock.
// R11: In I2C mode data lines one and two form SDA and line zero carries SCL.
// R12: The data lines are bidirectional and driven only during reads; the code also drives line one for the I2C acknowledge.
module dhi_host_port
  import dhi_pkg::*;
#(
  parameter logic [6:0] I2C_ADDR = `DHI_I2C_ADDR_DEF,
  parameter logic [15:0] FRAME_CYC = `DHI_FRAME_CYC_DEF,
  parameter logic [15:0] PULSE_CYC = `DHI_FRAME_PULSE_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic reset_in_n,
  input wire logic bus_strap_a,
  input wire logic bus_strap_b,
  input wire logic cs_n,
  input wire logic dc_sel,
  input wire logic strobe_e_rd_n,
  input wire logic rw_wr_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic [7:0] data_oe,
  input wire logic [7:0] read_value,
  output logic read_taken,
  output dhi_byte_s wr_byte,
  output logic wr_valid,
  output logic [7:0] cmd_reg,
  output logic frame_sync_out
);
  //////////////////////////////////////////////////////////////////////////////
  logic srst;
  dhi_mode_e mode;
  logic e_q_ff, rd_q_ff, wr_q_ff, scl_q_ff, sda_q_ff;
  logic nxt_e_q, nxt_rd_q, nxt_wr_q, nxt_scl_q, nxt_sda_q;
  logic [7:0] dout_ff, nxt_dout;
  logic rd_act_ff, nxt_rd_act;
  dhi_byte_s wb_ff, nxt_wb;
  logic wv_ff, nxt_wv;
  logic [7:0] cmd_ff, nxt_cmd;
  logic [7:0] sh_ff, nxt_sh;
  logic [2:0] bit_ff, nxt_bit;
  logic i2c_on_ff, nxt_i2c_on;
  logic i2c_addr_ff, nxt_i2c_addr;
  logic i2c_dc_ff, nxt_i2c_dc;
  logic i2c_ctl_ff, nxt_i2c_ctl;
  logic ack_ff, nxt_ack;
  logic i2c_first_ff, nxt_i2c_first;
  logic scl_rise, scl_fall, sda_sda;

  // R08: external reset acts like the system reset
  assign srst = !reset_in_n;

  // R05: strap decode
  always_comb begin
    unique case ({bus_strap_a, bus_strap_b})
      `DHI_STRAP_8080: mode = DHI_M8080;
      `DHI_STRAP_I2C: mode = DHI_MI2C;
      `DHI_STRAP_6800: mode = DHI_M6800;
      `DHI_STRAP_SPI: mode = DHI_MSPI;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Parallel and serial decoding share one next-state block
  assign scl_rise = data_in[0] && !scl_q_ff;
  assign scl_fall = !data_in[0] && scl_q_ff;
  assign sda_sda = data_in[1];

  always_comb begin
    nxt_e_q = strobe_e_rd_n;
    nxt_rd_q = strobe_e_rd_n;
    nxt_wr_q = rw_wr_n;
    nxt_scl_q = data_in[0];
    nxt_sda_q = sda_sda;
    nxt_dout = dout_ff;
    nxt_rd_act = rd_act_ff;
    nxt_wb = wb_ff;
    nxt_wv = 1'b0;
    nxt_cmd = cmd_ff;
    nxt_sh = sh_ff;
    nxt_bit = bit_ff;
    nxt_i2c_on = i2c_on_ff;
    nxt_i2c_addr = i2c_addr_ff;
    nxt_i2c_dc = i2c_dc_ff;
    nxt_i2c_ctl = i2c_ctl_ff;
    nxt_ack = ack_ff;
    nxt_i2c_first = i2c_first_ff;
    read_taken = 1'b0;
    // R07: deselect ends any transfer
    if (cs_n) begin
      nxt_rd_act = 1'b0;
      nxt_bit = 3'h0;
      nxt_i2c_on = 1'b0;
      nxt_ack = 1'b0;
    end else begin
      unique case (mode)
        DHI_M6800: begin
          // R01: enable rising edge starts the access
          if (strobe_e_rd_n && !e_q_ff) begin
            // R02: direction picks read or write
            if (rw_wr_n) begin
              nxt_rd_act = 1'b1;
              nxt_dout = read_value;
              read_taken = 1'b1;
            end else begin
              nxt_wb = '{is_data: dc_sel, value: data_in};
              nxt_wv = 1'b1;
            end
          end
          if (!strobe_e_rd_n) begin
            nxt_rd_act = 1'b0;
          end
        end
        DHI_M8080: begin
          // R03: read strobe falling edge
          if (!strobe_e_rd_n && rd_q_ff) begin
            nxt_rd_act = 1'b1;
            nxt_dout = read_value;
            read_taken = 1'b1;
          end
          if (strobe_e_rd_n) begin
            nxt_rd_act = 1'b0;
          end
          // R04: write strobe falling edge
          if (!rw_wr_n && wr_q_ff) begin
            nxt_wb = '{is_data: dc_sel, value: data_in};
            nxt_wv = 1'b1;
          end
        end
        DHI_MSPI: begin
          nxt_rd_act = 1'b0;
          // R10: shift on clock line zero, data on line one
          if (scl_rise) begin
            nxt_sh = {sh_ff[6:0], sda_sda};
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == `DHI_SPI_LAST_BIT) begin
              nxt_wb = '{is_data: dc_sel, value: {sh_ff[6:0], sda_sda}};
              nxt_wv = 1'b1;
            end
          end
        end
        DHI_MI2C: begin
          nxt_rd_act = 1'b0;
          // R11: start and stop seen on SDA while SCL high
          if (data_in[0] && scl_q_ff && sda_q_ff && !sda_sda) begin
            nxt_i2c_on = 1'b1;
            nxt_i2c_addr = 1'b1;
            nxt_i2c_first = 1'b1;
            nxt_bit = 3'h0;
            nxt_ack = 1'b0;
          end else if (data_in[0] && scl_q_ff && !sda_q_ff && sda_sda) begin
            nxt_i2c_on = 1'b0;
            nxt_ack = 1'b0;
          end else if (i2c_on_ff && scl_rise && !ack_ff) begin
            nxt_sh = {sh_ff[6:0], sda_sda};
            nxt_bit = bit_ff + 3'h1;
          end else if (i2c_on_ff && scl_fall) begin
            if (ack_ff) begin
              nxt_ack = 1'b0;
            end else if (bit_ff == 3'h0 && !i2c_first_ff) begin
              // Full byte: acknowledge (an address byte only if it matches with the write bit low), and deliver it if it is a data byte
              if (i2c_addr_ff) begin
                nxt_i2c_addr = 1'b0;
                nxt_ack = (sh_ff[7:1] == I2C_ADDR) && !sh_ff[0];
                nxt_i2c_on = nxt_ack;
                nxt_i2c_ctl = 1'b1;
              end else if (i2c_ctl_ff) begin
                // R06: control byte bit 6 carries data/command
                nxt_i2c_dc = sh_ff[6];
                nxt_i2c_ctl = 1'b0;
                nxt_ack = 1'b1;
              end else begin
                nxt_wb = '{is_data: i2c_dc_ff, value: sh_ff};
                nxt_wv = 1'b1;
                nxt_ack = 1'b1;
              end
            end
            nxt_i2c_first = 1'b0;
          end
        end
      endcase
    end
    // R06: commands land in the command register
    if (nxt_wv && !nxt_wb.is_data) begin
      nxt_cmd = nxt_wb.value;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      e_q_ff <= 1'b0;
      rd_q_ff <= 1'b1;
      wr_q_ff <= 1'b1;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      dout_ff <= `DHI_ZERO_BYTE;
      rd_act_ff <= 1'b0;
      wb_ff <= '0;
      wv_ff <= 1'b0;
      cmd_ff <= `DHI_ZERO_BYTE;
      sh_ff <= `DHI_ZERO_BYTE;
      bit_ff <= 3'h0;
      i2c_on_ff <= 1'b0;
      i2c_addr_ff <= 1'b0;
      i2c_dc_ff <= 1'b0;
      i2c_ctl_ff <= 1'b0;
      ack_ff <= 1'b0;
      i2c_first_ff <= 1'b0;
    end else if (srst) begin
      // R08: synchronous reinitialise from reset pin
      e_q_ff <= 1'b0;
      rd_q_ff <= 1'b1;
      wr_q_ff <= 1'b1;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      dout_ff <= `DHI_ZERO_BYTE;
      rd_act_ff <= 1'b0;
      wb_ff <= '0;
      wv_ff <= 1'b0;
      cmd_ff <= `DHI_ZERO_BYTE;
      sh_ff <= `DHI_ZERO_BYTE;
      bit_ff <= 3'h0;
      i2c_on_ff <= 1'b0;
      i2c_addr_ff <= 1'b0;
      i2c_dc_ff <= 1'b0;
      i2c_ctl_ff <= 1'b0;
      ack_ff <= 1'b0;
      i2c_first_ff <= 1'b0;
    end else begin
      e_q_ff <= nxt_e_q;
      rd_q_ff <= nxt_rd_q;
      wr_q_ff <= nxt_wr_q;
      scl_q_ff <= nxt_scl_q;
      sda_q_ff <= nxt_sda_q;
      dout_ff <= nxt_dout;
      rd_act_ff <= nxt_rd_act;
      wb_ff <= nxt_wb;
      wv_ff <= nxt_wv;
      cmd_ff <= nxt_cmd;
      sh_ff <= nxt_sh;
      bit_ff <= nxt_bit;
      i2c_on_ff <= nxt_i2c_on;
      i2c_addr_ff <= nxt_i2c_addr;
      i2c_dc_ff <= nxt_i2c_dc;
      i2c_ctl_ff <= nxt_i2c_ctl;
      ack_ff <= nxt_ack;
      i2c_first_ff <= nxt_i2c_first;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // R12: drive the bus only for reads, or line one for the I2C acknowledge
  assign data_out = dout_ff & {8{rd_act_ff}};
  assign data_oe = rd_act_ff ? 8'hFF : {6'h00, ack_ff, 1'b0};
  assign wr_byte = wb_ff;
  assign wr_valid = wv_ff;
  assign cmd_reg = cmd_ff;

  dhi_frame_sync #(
    .FRAME_CYC(FRAME_CYC),
    .PULSE_CYC(PULSE_CYC)
  ) u_fs (
    .clk(clk),
    .rstn(rstn),
    .srst(srst),
    .frame_sync_out(frame_sync_out)
  );

  //////////////////////////////////////////////////////////////////////////////
  // R07: deselected bus stays quiet
  desel_quiet_a: assert property (@(posedge clk) disable iff (!rstn || srst)
    $past(cs_n) |-> !wv_ff && !rd_act_ff) else $error("activity while deselected"); // R07
  // R01: 6800 write on enable rise
  e_write_a: assert property (@(posedge clk) disable iff (!rstn || srst)
    mode == DHI_M6800 && !cs_n && strobe_e_rd_n && !e_q_ff && !rw_wr_n
    |=> wv_ff && wb_ff.value == $past(data_in)) else $error("6800 write lost"); // R01
  // R02: 6800 read direction
  e_read_a: assert property (@(posedge clk) disable iff (!rstn || srst)
    mode == DHI_M6800 && !cs_n && strobe_e_rd_n && !e_q_ff && rw_wr_n
    |=> rd_act_ff && !wv_ff) else $error("6800 read wrong"); // R02
  // R03: 8080 read strobe
  rd_strobe_a: assert property (@(posedge clk) disable iff (!rstn || srst)
    mode == DHI_M8080 && !cs_n && !strobe_e_rd_n && rd_q_ff
    |=> rd_act_ff && dout_ff == $past(read_value)) else $error("8080 read wrong"); // R03
  // R04: 8080 write strobe
  wr_strobe_a: assert property (@(posedge clk) disable iff (!rstn || srst)
    mode == DHI_M8080 && !cs_n && !rw_wr_n && wr_q_ff
    |=> wv_ff && wb_ff.is_data == $past(dc_sel)) else $error("8080 write lost"); // R04
  // R06: command register capture
  cmd_capture_a: assert property (@(posedge clk) disable iff (!rstn || srst)
    wv_ff && !wb_ff.is_data |-> cmd_ff == wb_ff.value) else $error("command not held"); // R06
  // R12: drive only for reads
  bus_drive_a: assert property (@(posedge clk) disable iff (!rstn)
    data_oe == 8'hFF |-> rd_act_ff) else $error("bus driven outside read"); // R12
  // R08: reset pin clears state
  pin_reset_a: assert property (@(posedge clk) disable iff (!rstn)
    srst |=> cmd_ff == `DHI_ZERO_BYTE && !wv_ff) else $error("reset pin ignored"); // R08
  // R10: eight clocks make a byte
  spi_byte_a: assert property (@(posedge clk) disable iff (!rstn || srst)
    mode == DHI_MSPI && !cs_n && scl_rise && bit_ff == `DHI_SPI_LAST_BIT
    |=> wv_ff) else $error("spi byte lost"); // R10
  par_write_c: cover property (@(posedge clk) wv_ff && mode == DHI_M8080);
  spi_write_c: cover property (@(posedge clk) wv_ff && mode == DHI_MSPI);
  i2c_write_c: cover property (@(posedge clk) wv_ff && mode == DHI_MI2C);
  read_c: cover property (@(posedge clk) rd_act_ff);
endmodule

/* sim/dhi_host_model.sv */
`timescale 1ns/1ps
`include "dhi_defs.svh"
module dhi_host_model (
  input wire logic clk,
  input wire logic [7:0] data_out,
  input wire logic [7:0] data_oe,
  output logic [1:0] straps,
  output logic cs_n,
  output logic dc_sel,
  output logic e_rd,
  output logic rw_wr,
  output logic [7:0] d
);
  logic [7:0] pd;
  logic h_sda;
  logic sda_w;
  assign sda_w = h_sda & ~(data_oe[1] & ~data_out[1]);
  assign d = (straps == `DHI_STRAP_I2C) ? {pd[7:3], {2{sda_w}}, pd[0]} : pd;
  initial begin
    straps = `DHI_STRAP_8080;
    cs_n = 1'b1;
    dc_sel = 1'b0;
    e_rd = 1'b1;
    rw_wr = 1'b1;
    pd = 8'h00;
    h_sda = 1'b1;
  end
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task set_mode(input logic [1:0] m);
    // straps, then idle strobe levels of that bus
    straps = m;
    cs_n = 1'b1;
    e_rd = (m == `DHI_STRAP_8080);
    rw_wr = (m == `DHI_STRAP_8080);
    h_sda = 1'b1;
    pd = 8'h00;
    cyc(2);
  endtask
  task put(input logic dc, input logic [7:0] v, input logic sel_n);
    integer i;
    cs_n = sel_n;
    dc_sel = dc;
    if (straps == `DHI_STRAP_SPI) begin
      // MSB first, clock on line zero
      for (i = 7; i >= 0; i--) begin
        pd = {5'h00, {2{v[i]}}, 1'b0};
        cyc(1);
        pd[0] = 1'b1;
        cyc(1);
      end
      pd[0] = 1'b0;
    end else begin
      pd = v;
      if (straps == `DHI_STRAP_8080) rw_wr = 1'b0;
      else e_rd = 1'b1;
      cyc(2);
      rw_wr = (straps == `DHI_STRAP_8080);
      e_rd = (straps == `DHI_STRAP_8080);
    end
    cyc(1);
    cs_n = 1'b1;
    // Released lines must not keep the old value
    pd = (straps == `DHI_STRAP_SPI) ? pd ^ 8'h06 : ~pd;
    cyc(1);
  endtask
  task get(output logic [7:0] rv, output logic [7:0] oe);
    cs_n = 1'b0;
    dc_sel = 1'b1;
    if (straps == `DHI_STRAP_8080) e_rd = 1'b0;
    else begin
      rw_wr = 1'b1;
      e_rd = 1'b1;
    end
    cyc(3);
    // host reads what the device drives
    rv = data_out;
    oe = data_oe;
    e_rd = (straps == `DHI_STRAP_8080);
    cyc(1);
    rw_wr = (straps == `DHI_STRAP_8080);
    cs_n = 1'b1;
    cyc(2);
  endtask
  task scl_bit(input logic b, output logic s);
    h_sda = b;
    cyc(1);
    pd[0] = 1'b1;
    cyc(1);
    s = sda_w;
    cyc(1);
    pd[0] = 1'b0;
    cyc(1);
  endtask
  task i2c_byte(input logic [7:0] v, output logic ack);
    integer i;
    logic s;
    for (i = 7; i >= 0; i--) scl_bit(v[i], s);
    scl_bit(1'b1, s);
    ack = ~s;
  endtask
  task i2c_cond(input logic start);
    cs_n = 1'b0;
    h_sda = start;
    cyc(1);
    pd[0] = 1'b1;
    cyc(2);
    h_sda = ~start;
    cyc(2);
    if (start) pd[0] = 1'b0;
    cyc(1);
  endtask
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
`include "dhi_defs.svh"
module testbench;
  import dhi_pkg::*;
  typedef struct packed {logic [1:0] strap; logic dc; logic [7:0] v; logic [7:0] cmd;} dhi_row_s;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic reset_in_n = 1'b1;
  logic [7:0] read_value = 8'h96;
  logic [1:0] straps;
  logic cs_n, dc_sel, e_rd, rw_wr, read_taken, wr_valid, frame_sync_out, ack;
  logic [7:0] d, data_out, data_oe, cmd_reg, rv, oe;
  dhi_byte_s wr_byte, got;
  int n_errors = 0, compares = 0, n_wr = 0, n_rd = 0, cycles = 0, i, k;
  logic [7:0] ib [3] = '{8'h78, 8'h40, 8'hC3};
  dhi_row_s rows [6] = '{'{`DHI_STRAP_8080, 1'b0, 8'hA1, 8'hA1},
    '{`DHI_STRAP_8080, 1'b1, 8'h5C, 8'hA1}, '{`DHI_STRAP_6800, 1'b0, 8'h0F, 8'h0F},
    '{`DHI_STRAP_6800, 1'b1, 8'hF0, 8'h0F}, '{`DHI_STRAP_SPI, 1'b0, 8'h81, 8'h81},
    '{`DHI_STRAP_SPI, 1'b1, 8'h7E, 8'h81}};
  always #4 clk = ~clk;
  dhi_host_port #(.I2C_ADDR(7'h3C), .FRAME_CYC(16'h0020), .PULSE_CYC(16'h0004)) dhi_host_port_i (
    .clk(clk), .rstn(rstn), .reset_in_n(reset_in_n), .bus_strap_a(straps[1]),
    .bus_strap_b(straps[0]), .cs_n(cs_n), .dc_sel(dc_sel), .strobe_e_rd_n(e_rd),
    .rw_wr_n(rw_wr), .data_in(d), .data_out(data_out), .data_oe(data_oe),
    .read_value(read_value), .read_taken(read_taken), .wr_byte(wr_byte),
    .wr_valid(wr_valid), .cmd_reg(cmd_reg), .frame_sync_out(frame_sync_out));
  dhi_host_model dhi_host_model_i (.clk(clk), .data_out(data_out), .data_oe(data_oe),
    .straps(straps), .cs_n(cs_n), .dc_sel(dc_sel), .e_rd(e_rd), .rw_wr(rw_wr), .d(d));
  //////////////////////////////////////////////////////////////////////////////
  task stop_test();
    if (n_errors == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e, input string m);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask
  // Each write pulse is counted, so a doubled or lost pulse shows up
  always @(posedge clk) begin
    cycles++;
    if (wr_valid === 1'b1) begin
      got = wr_byte;
      n_wr++;
    end
    if (read_taken === 1'b1) begin
      n_rd++;
    end
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    for (i = 0; i < 6; i++) begin
      dhi_host_model_i.set_mode(rows[i].strap);
      k = n_wr;
      dhi_host_model_i.put(rows[i].dc, rows[i].v, 1'b0);
      chk(16'(n_wr - k), 16'h0001, "write pulse");
      chk(16'(got), {7'h00, rows[i].dc, rows[i].v}, "write byte");
      chk(16'(cmd_reg), 16'(rows[i].cmd), "command");
    end
    dhi_host_model_i.set_mode(`DHI_STRAP_8080);
    k = n_wr;
    dhi_host_model_i.put(1'b0, 8'h33, 1'b1);
    chk(16'(n_wr - k), 16'h0000, "deselected write");
    chk(16'(cmd_reg), 16'h0081, "deselected command");
    for (i = 0; i < 2; i++) begin
      dhi_host_model_i.set_mode(i ? `DHI_STRAP_6800 : `DHI_STRAP_8080);
      k = n_rd;
      dhi_host_model_i.get(rv, oe);
      chk(16'(n_rd - k), 16'h0001, "read pulse");
      chk(16'(rv), 16'h0096, "read data");
      chk(16'(oe), 16'h00FF, "read enable");
      chk(16'(data_oe), 16'h0000, "bus released");
    end
    // Address, control byte with data flag, then one data byte
    dhi_host_model_i.set_mode(`DHI_STRAP_I2C);
    k = n_wr;
    dhi_host_model_i.i2c_cond(1'b1);
    for (i = 0; i < 3; i++) begin
      dhi_host_model_i.i2c_byte(ib[i], ack);
      chk(16'(ack), 16'h0001, "serial ack");
    end
    dhi_host_model_i.i2c_cond(1'b0);
    chk(16'(n_wr - k), 16'h0001, "serial count");
    chk(16'(got), 16'h01C3, "serial byte");
    dhi_host_model_i.set_mode(`DHI_STRAP_8080);
    reset_in_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(16'(cmd_reg), 16'h0000, "pin reset command");
    chk(16'(frame_sync_out), 16'h0000, "pin reset sync");
    reset_in_n = 1'b1;
    k = 0;
    while (frame_sync_out !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    k = 0;
    while (frame_sync_out === 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk(16'(k), 16'h0004, "sync width");
    while (frame_sync_out !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk(16'(k), 16'h0020, "sync period");
    stop_test();
  end
endmodule
